// >>> src/ils_pkg.sv
package ils_pkg;
	// ------------------------------------------------------------
	// device register map on the link
	// ------------------------------------------------------------
	localparam logic [7:0] DEV_ST0 = 8'h40;
	localparam logic [7:0] DEV_ST1 = 8'h41;
	localparam logic [7:0] DEV_EN0 = 8'h42;
	localparam logic [7:0] DEV_EN1 = 8'h43;
	localparam logic [7:0] DEV_IO_POWER = 8'h44;
	localparam logic [7:0] EN0_RST = 8'hFF;
	localparam logic [5:0] EN1_RST = 6'h3F;
	// group0 bits: 0 end of packet, 1 rx empty, 2 rx full, 3 osc ready,
	// 4 self init, 5 flash done, 6 packet sent, 7 packet received
	// group1 bits: 0 wake, 1 link change, 2 jabber, 3 neg fail,
	// 4 remote fault, 5 neg done
	localparam int OSC_BIT = 3;
	localparam int SELF_BIT = 4;
	localparam int LINKCHG_BIT = 1;
	// io_power_ctrl bits
	localparam int PWR_LINK = 0;
	localparam int PWR_TRAFFIC = 1;
	localparam int PWR_COMBINED = 2;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int ACT_MS = 50;
	localparam int ACT_CYCLES = ACT_MS * (CLK_HZ / 1000);
	localparam int ACT_W = 21;
	localparam int POLL_US = 1000;
	localparam int POLL_CYCLES = POLL_US * (CLK_HZ / 1_000_000);
	localparam int POLL_W = 20;
	typedef logic [ACT_W-1:0] ils_act_t;
	typedef logic [POLL_W-1:0] ils_poll_t;
	// ------------------------------------------------------------
	// host apb map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] A_CFG_EN = 8'h00;
	localparam logic [7:0] A_CFG_LED = 8'h04;
	localparam logic [7:0] A_POLL = 8'h08;
	localparam logic [7:0] A_CMD = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_PEND = 8'h14;
	localparam logic [7:0] A_IST = 8'h18;
	localparam logic [7:0] A_IMASK = 8'h1C;
	localparam logic [13:0] CFG_EN_RST = 14'h3FFF;
	localparam logic [2:0] CFG_LED_RST = 3'h7;
	localparam int CMD_WR_BIT = 16;
	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] st0;
		logic [5:0] st1;
		logic [7:0] en0;
		logic [5:0] en1;
		logic [2:0] io_pwr;
		logic [7:0] rdata;
		logic osc_on;
		logic osc_seen;
		logic link_prev;
		ils_act_t act;
		logic [2:0] leds;
		logic int_n;
	} ils_dev_t;
	typedef enum logic [3:0] {
		H_OSC = 4'h0,
		H_SELF = 4'h1,
		H_EN0 = 4'h3,
		H_EN1 = 4'h2,
		H_LED = 4'h6,
		H_IDLE = 4'h7,
		H_SVC0 = 4'h5,
		H_SVC1 = 4'h4,
		H_CMD = 4'hC
	} ils_hstate_t;
	typedef struct packed {
		ils_hstate_t state;
		logic acc;
		logic cap;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [13:0] cfg_en;
		logic [2:0] cfg_led;
		logic poll_en;
		ils_poll_t poll_cnt;
		logic cmd_pend;
		logic cmd_wr;
		logic [7:0] cmd_addr;
		logic [7:0] cmd_data;
		logic [7:0] rdata_last;
		logic [13:0] pend;
		logic [2:0] ist;
		logic [2:0] imask;
		logic [31:0] prdata;
		logic init_done;
	} ils_host_t;
endpackage : ils_pkg

// >>> src/ils_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ils_link_if;
	logic cs;
	logic rd;
	logic wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic int_n;
	modport dev(input cs, rd, wr, addr, wdata, output rdata, int_n);
	modport host(output cs, rd, wr, addr, wdata, input rdata, int_n);
endinterface : ils_link_if
`default_nettype wire

// >>> src/ils_device.sv
// Behaviour
// R1: request asserts on any enabled pending event
// R2: fourteen interrupt sources in two groups
// R3: enables reset to one, individually clearable
// R4: reading a status register clears its flags
// R5: host without request line polls status
// R6: oscillator ready is signalled through the request
// R7: host waits oscillator, then polls self-init
// R8: host disables enables it will not service
// R9: host finishes led setup before traffic
// R10: oscillator runs from reset release until reset
// R11: link led follows valid link pulses
// R12: traffic led lit 50 ms per packet
// R13: combined led follows link, toggles on traffic
// R14: each led driver gated by power control
// R15: request is a dedicated output pin
// R16: request is active low and level held
// R17: event during clearing read stays pending
`timescale 1ns/10ps
`default_nettype none
module ils_device
	import ils_pkg::*;
#(
	parameter int ACT_LEN = ACT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	ils_link_if.dev lnk,
	input wire logic [13:0] events,
	input wire logic osc_stable,
	input wire logic link_ok,
	input wire logic pkt_activity,
	output logic osc_run,
	output logic link_led,
	output logic link_led_oe,
	output logic traffic_led,
	output logic traffic_led_oe,
	output logic combined_led,
	output logic combined_led_oe
);
	// ------------------------------------------------------------
	// reset image
	// ------------------------------------------------------------
	localparam ils_dev_t DEV_RST = '{
		st0: 8'h00,
		st1: 6'h00,
		en0: EN0_RST,
		en1: EN1_RST,
		io_pwr: 3'h0,
		rdata: 8'h00,
		osc_on: 1'b0,
		osc_seen: 1'b0,
		link_prev: 1'b0,
		act: '0,
		leds: 3'h0,
		int_n: 1'b1
	};

	ils_dev_t q;
	ils_dev_t next_q;
	logic [7:0] ev0;
	logic [5:0] ev1;
	logic rd_hit;
	logic wr_hit;
	logic busy;
	logic [7:0] live0;
	logic [5:0] live1;
	logic [2:0] led_pin;
	logic [2:0] led_pin_oe;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_q = q;
		// ------------------------------------------------------------
		// oscillator and link edge
		// ------------------------------------------------------------
		// oscillator held off only while reset is low
		next_q.osc_on = 1'b1; // R10
		next_q.osc_seen = q.osc_seen | (q.osc_on & osc_stable);
		next_q.link_prev = link_ok;
		rd_hit = lnk.cs & lnk.rd;
		wr_hit = lnk.cs & lnk.wr;

		// ------------------------------------------------------------
		// event collection
		// ------------------------------------------------------------
		ev0 = events[7:0]; // R2
		ev1 = events[13:8]; // R2
		// one shot on first stable edge after start
		ev0[OSC_BIT] = events[OSC_BIT] | (q.osc_on & osc_stable & ~q.osc_seen); // R6
		ev1[LINKCHG_BIT] = events[8 + LINKCHG_BIT] | (link_ok ^ q.link_prev);

		// ------------------------------------------------------------
		// read data and clear-on-read
		// ------------------------------------------------------------
		next_q.rdata = 8'h00;
		if (rd_hit) begin
			unique case (lnk.addr)
				DEV_ST0: begin
					next_q.rdata = q.st0;
					next_q.st0 = 8'h00; // R4
				end
				DEV_ST1: begin
					next_q.rdata = {2'h0, q.st1};
					next_q.st1 = 6'h00; // R4
				end
				DEV_EN0: begin
					next_q.rdata = q.en0;
				end
				DEV_EN1: begin
					next_q.rdata = {2'h0, q.en1};
				end
				DEV_IO_POWER: begin
					next_q.rdata = {5'h00, q.io_pwr};
				end
				default: begin
					next_q.rdata = 8'h00;
				end
			endcase
		end
		// events merged after the clear so a same-cycle event survives
		next_q.st0 = next_q.st0 | ev0; // R17
		next_q.st1 = next_q.st1 | ev1; // R17

		// ------------------------------------------------------------
		// control writes
		// ------------------------------------------------------------
		if (wr_hit) begin
			unique case (lnk.addr)
				DEV_EN0: begin
					next_q.en0 = lnk.wdata; // R3
				end
				DEV_EN1: begin
					next_q.en1 = lnk.wdata[5:0]; // R3
				end
				DEV_IO_POWER: begin
					next_q.io_pwr = lnk.wdata[2:0];
				end
				default: begin
					next_q.io_pwr = q.io_pwr;
				end
			endcase
		end

		// ------------------------------------------------------------
		// request
		// ------------------------------------------------------------
		// request follows pending state, not single events, so a host
		// that is late to look still finds the line low
		live0 = next_q.st0 & next_q.en0; // R1
		live1 = next_q.st1 & next_q.en1; // R1
		next_q.int_n = ~(|live0 | |live1); // R1 R16

		// ------------------------------------------------------------
		// traffic timer
		// ------------------------------------------------------------
		// retriggered by each packet; a long burst keeps the led lit
		if (pkt_activity) begin
			next_q.act = ils_act_t'(ACT_LEN); // R12
		end else if (q.act != '0) begin
			next_q.act = q.act - ils_act_t'(1);
		end
		busy = (next_q.act != '0);

		// ------------------------------------------------------------
		// led images
		// ------------------------------------------------------------
		// gated off while their driver is disabled
		next_q.leds[PWR_LINK] = link_ok & next_q.io_pwr[PWR_LINK]; // R11 R14
		next_q.leds[PWR_TRAFFIC] = busy & next_q.io_pwr[PWR_TRAFFIC]; // R12 R14
		// blink reads as link dark during the window
		next_q.leds[PWR_COMBINED] = link_ok & ~busy & next_q.io_pwr[PWR_COMBINED]; // R13 R14
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= DEV_RST; // R3
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// the pin is its own wire; nothing else shares it
	assign lnk.int_n = q.int_n; // R15 R16
	assign lnk.rdata = q.rdata;
	assign osc_run = q.osc_on; // R10
	// ------------------------------------------------------------
	// led drivers
	// ------------------------------------------------------------
	// all three drivers share one shape: level from the image, enable from
	// its power bit; disabled drivers float instead of pulling the led low
	for (genvar i = 0; i < 3; i++) begin : g_led
		assign led_pin[i] = q.leds[i]; // R14
		assign led_pin_oe[i] = q.io_pwr[i]; // R14
	end
	assign link_led = led_pin[PWR_LINK]; // R11
	assign traffic_led = led_pin[PWR_TRAFFIC]; // R12
	assign combined_led = led_pin[PWR_COMBINED]; // R13
	assign link_led_oe = led_pin_oe[PWR_LINK]; // R14
	assign traffic_led_oe = led_pin_oe[PWR_TRAFFIC]; // R14
	assign combined_led_oe = led_pin_oe[PWR_COMBINED]; // R14
endmodule : ils_device
`default_nettype wire

// >>> src/ils_host.sv
`timescale 1ns/10ps
`default_nettype none
module ils_host
	import ils_pkg::*;
#(
	parameter int POLL_LEN = POLL_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	ils_link_if.host lnk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic link_ready
);
	// ------------------------------------------------------------
	// reset image
	// ------------------------------------------------------------
	localparam ils_host_t HOST_RST = '{
		state: H_OSC, acc: 1'b0, cap: 1'b0, wr: 1'b0,
		addr: 8'h00, wdata: 8'h00, cfg_en: CFG_EN_RST,
		cfg_led: CFG_LED_RST, poll_en: 1'b0, poll_cnt: '0,
		cmd_pend: 1'b0, cmd_wr: 1'b0, cmd_addr: 8'h00,
		cmd_data: 8'h00, rdata_last: 8'h00, pend: 14'h0000,
		ist: 3'h0, imask: 3'h0, prdata: 32'h0000_0000,
		init_done: 1'b0
	};

	ils_host_t q;
	ils_host_t next_q;
	logic go;
	logic wr_acc;
	logic [2:0] ist_set;
	logic [2:0] ist_clr;
	logic [13:0] pend_set;
	logic [13:0] pend_clr;

	function automatic ils_host_t launch(ils_host_t s, logic w, logic [7:0] a,
		logic [7:0] d);
		ils_host_t r;
		r = s;
		r.acc = 1'b1;
		r.wr = w;
		r.addr = a;
		r.wdata = d;
		return r;
	endfunction : launch

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_q = q;
		ist_set = 3'h0;
		pend_set = 14'h0000;
		go = !q.acc && !q.cap;
		// one strobe cycle, then one cycle to take the answer
		if (q.acc) begin
			next_q.acc = 1'b0;
			next_q.cap = 1'b1;
		end
		if (q.cap) begin
			next_q.cap = 1'b0;
		end
		if (q.poll_cnt != '0) begin
			next_q.poll_cnt = q.poll_cnt - ils_poll_t'(1);
		end

		unique case (q.state)
			H_OSC: begin
				if (!lnk.int_n) begin
					next_q.state = H_SELF; // R7
				end
			end
			H_SELF: begin
				if (go) begin
					next_q = launch(next_q, 1'b0, DEV_ST0, 8'h00);
				end
				if (q.cap) begin
					pend_set[7:0] = lnk.rdata;
					if (lnk.rdata[SELF_BIT]) begin
						next_q.state = H_EN0; // R7
					end
				end
			end
			H_EN0: begin
				if (go) begin
					next_q = launch(next_q, 1'b1, DEV_EN0, q.cfg_en[7:0]); // R8
				end
				if (q.cap) begin
					next_q.state = H_EN1;
				end
			end
			H_EN1: begin
				if (go) begin
					next_q = launch(next_q, 1'b1, DEV_EN1, {2'h0, q.cfg_en[13:8]}); // R8
				end
				if (q.cap) begin
					next_q.state = H_LED;
				end
			end
			H_LED: begin
				if (go) begin
					next_q = launch(next_q, 1'b1, DEV_IO_POWER, {5'h00, q.cfg_led});
				end
				if (q.cap) begin
					next_q.state = H_IDLE;
					next_q.init_done = 1'b1; // R9
					ist_set[0] = 1'b1;
				end
			end
			H_IDLE: begin
				if (q.cmd_pend) begin
					next_q.state = H_CMD;
				end else if (!lnk.int_n) begin
					next_q.state = H_SVC0;
				end else if (q.poll_en && q.poll_cnt == '0) begin
					next_q.state = H_SVC0; // R5
					next_q.poll_cnt = ils_poll_t'(POLL_LEN);
				end
			end
			H_SVC0: begin
				if (go) begin
					next_q = launch(next_q, 1'b0, DEV_ST0, 8'h00);
				end
				if (q.cap) begin
					pend_set[7:0] = lnk.rdata; // R5
					next_q.state = H_SVC1;
				end
			end
			H_SVC1: begin
				if (go) begin
					next_q = launch(next_q, 1'b0, DEV_ST1, 8'h00);
				end
				if (q.cap) begin
					pend_set[13:8] = lnk.rdata[5:0]; // R5
					next_q.state = H_IDLE;
				end
			end
			H_CMD: begin
				if (go) begin
					next_q = launch(next_q, q.cmd_wr, q.cmd_addr, q.cmd_data);
				end
				if (q.cap) begin
					next_q.rdata_last = lnk.rdata;
					next_q.cmd_pend = 1'b0;
					ist_set[1] = 1'b1;
					next_q.state = H_IDLE;
				end
			end
			default: begin
				next_q.state = H_OSC;
			end
		endcase
		if (|(pend_set & ~q.pend)) begin
			ist_set[2] = 1'b1;
		end

		// apb slave, zero wait; read data loaded in the setup cycle
		wr_acc = psel & penable & pwrite;
		ist_clr = 3'h0;
		pend_clr = 14'h0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				A_CFG_EN: next_q.prdata = {18'h00000, q.cfg_en};
				A_CFG_LED: next_q.prdata = {29'h0, q.cfg_led};
				A_POLL: next_q.prdata = {31'h0, q.poll_en};
				A_STAT: next_q.prdata = {16'h0000, q.rdata_last, 5'h00,
					!lnk.int_n, q.init_done, q.cmd_pend};
				A_PEND: next_q.prdata = {18'h00000, q.pend};
				A_IST: next_q.prdata = {29'h0, q.ist};
				A_IMASK: next_q.prdata = {29'h0, q.imask};
				default: next_q.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc) begin
			unique case (paddr)
				A_CFG_EN: next_q.cfg_en = pwdata[13:0];
				A_CFG_LED: next_q.cfg_led = pwdata[2:0];
				A_POLL: next_q.poll_en = pwdata[0];
				A_CMD: begin
					// a command while one is outstanding is dropped
					if (!q.cmd_pend) begin
						next_q.cmd_pend = 1'b1;
						next_q.cmd_wr = pwdata[CMD_WR_BIT];
						next_q.cmd_addr = pwdata[7:0];
						next_q.cmd_data = pwdata[15:8];
					end
				end
				A_PEND: pend_clr = pwdata[13:0];
				A_IST: ist_clr = pwdata[2:0];
				A_IMASK: next_q.imask = pwdata[2:0];
				default: next_q.imask = q.imask;
			endcase
		end
		// set wins over a write-one clear in the same cycle
		next_q.ist = (q.ist & ~ist_clr) | ist_set;
		next_q.pend = (q.pend & ~pend_clr) | pend_set;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= HOST_RST;
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign lnk.cs = q.acc;
	assign lnk.rd = q.acc & ~q.wr;
	assign lnk.wr = q.acc & q.wr;
	assign lnk.addr = q.addr;
	assign lnk.wdata = q.wdata;
	assign prdata = q.prdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(q.ist & q.imask);
	assign link_ready = q.init_done;
endmodule : ils_host
`default_nettype wire

// >>> sim/ils_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ils_assertions
	import ils_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic int_n
);
	// ------------------------------------------------
	// shadow of the writable device registers
	// ------------------------------------------------
	logic [7:0] en0_m;
	logic [5:0] en1_m;
	logic [2:0] pwr_m;
	logic st_rd;
	assign st_rd = cs && rd && (addr == DEV_ST0 || addr == DEV_ST1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en0_m <= EN0_RST;
			en1_m <= EN1_RST;
			pwr_m <= 3'h0;
		end else if (cs && wr) begin
			if (addr == DEV_EN0) en0_m <= wdata;
			if (addr == DEV_EN1) en1_m <= wdata[5:0];
			if (addr == DEV_IO_POWER) pwr_m <= wdata[2:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rdata_idle: assert property (
		!(cs && rd) |=> rdata == 8'h00) else $error("rdata not idle");
	a_strobe_pulse: assert property (
		cs |=> !cs) else $error("strobe longer than one cycle");
	a_strobe_kind: assert property (
		cs |-> rd ^ wr) else $error("strobe kind unclear");
	a_en0_back: assert property (
		cs && rd && addr == DEV_EN0 |=> rdata == en0_m) else $error("en0 readback");
	a_en1_back: assert property (
		cs && rd && addr == DEV_EN1 |=> rdata == {2'b00, en1_m}) else $error("en1 readback");
	a_pwr_back: assert property (
		cs && rd && addr == DEV_IO_POWER |=> rdata == {5'h00, pwr_m}) else $error("pwr readback");
	a_st1_width: assert property (
		cs && rd && addr == DEV_ST1 |=> rdata[7:6] == 2'b00) else $error("st1 upper bits");
	a_int_held: assert property (
		!int_n && !cs |=> !int_n) else $error("request dropped alone");
	a_int_release: assert property (
		$rose(int_n) |-> $past(st_rd) || $past(cs && wr)) else $error("request released alone");
	a_int_flag: assert property (
		cs && rd && addr == DEV_ST0 ##1 (rdata & en0_m) != 8'h00 |-> $past(!int_n))
		else $error("enabled flag without request");
	c_st_read: cover property (st_rd ##1 rdata != 8'h00);
	c_int_fall: cover property ($fell(int_n));
	c_pwr_wr: cover property (cs && wr && addr == DEV_IO_POWER);
endmodule : ils_assertions
`default_nettype wire

// >>> sim/irq_init_led_status_bench.sv
`timescale 1ns/10ps
`default_nettype none
module irq_init_led_status_bench;
	import ils_pkg::*;
	// short led window keeps the run brief
	localparam int ACTL = 20;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, q;
	logic [31:0] pwdata = 32'h0, prdata, rd, v, pend_m;
	logic [13:0] events = 14'h0;
	logic osc_stable = 0, link_ok = 0, pkt_activity = 0;
	logic pready, pslverr, irq, link_ready, osc_run;
	logic link_led, link_led_oe, traffic_led, traffic_led_oe, combined_led, combined_led_oe;
	int error_cnt = 0, n_checks = 0, n;
	int unsigned seed = 45;
	logic [7:0] ta [4] = '{DEV_EN0, DEV_EN1, 8'h50, DEV_IO_POWER};
	logic [7:0] tm [4] = '{8'hFF, 8'h3F, 8'h00, 8'h07};
	always #20 pclk = ~pclk;
	ils_link_if lnk ();
	ils_device #(.ACT_LEN(ACTL)) i_ils_device (.pclk(pclk), .presetn(presetn),
		.lnk(lnk.dev), .events(events), .osc_stable(osc_stable), .link_ok(link_ok),
		.pkt_activity(pkt_activity), .osc_run(osc_run), .link_led(link_led),
		.link_led_oe(link_led_oe), .traffic_led(traffic_led),
		.traffic_led_oe(traffic_led_oe), .combined_led(combined_led),
		.combined_led_oe(combined_led_oe));
	ils_host #(.POLL_LEN(10)) i_ils_host (.pclk(pclk), .presetn(presetn), .lnk(lnk.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link_ready(link_ready));
	ils_assertions i_ils_assertions (.pclk(pclk), .presetn(presetn), .cs(lnk.cs),
		.rd(lnk.rd), .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
		.int_n(lnk.int_n));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task chkb(input string nm, input logic e, input logic s);
		chk(nm, {31'h0, e}, {31'h0, s});
	endtask : chkb
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task cmd(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		logic [31:0] s;
		apb(1, A_CMD, {15'h0, w, d, a}, s);
		s = 32'h1;
		while (s[0] !== 1'b0) begin
			apb(0, A_STAT, 32'h0, s);
		end
		r = s[15:8];
	endtask : cmd
	task give_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial begin
		#(40 * 20000);
		error_cnt++;
		give_verdict();
	end
	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		cyc(6);
		chkb("osc_run", 0, osc_run);
		chkb("int_n", 1, lnk.int_n);
		presetn <= 1;
		cyc(2);
		chkb("osc_run", 1, osc_run);
		apb(0, A_CFG_EN, 32'h0, rd);
		chk("cfg_en", 32'h3FFF, rd);
		apb(0, A_CFG_LED, 32'h0, rd);
		chk("cfg_led", 32'h7, rd);
		v = xs();
		apb(1, A_CFG_EN, {18'h0, v[13:0]}, rd);
		apb(1, A_POLL, 32'h1, rd);
		osc_stable <= 1;
		n = 0;
		while (lnk.int_n !== 1'b0 && n < 100) begin
			cyc(1);
			n++;
		end
		chkb("osc_req", 0, lnk.int_n);
		events <= 14'h10;
		cyc(1);
		events <= 14'h0;
		n = 0;
		while (link_ready !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		apb(0, A_STAT, 32'h0, rd);
		chkb("init", 1, rd[1]);
		chkb("link_oe", 1, link_led_oe);
		chkb("traffic_oe", 1, traffic_led_oe);
		chkb("comb_oe", 1, combined_led_oe);
		// init must leave the host's own enable choice in the device
		cmd(0, DEV_EN0, 8'h00, q);
		chk("en0_init", {24'h0, v[7:0]}, {24'h0, q});
		cmd(0, DEV_EN1, 8'h00, q);
		chk("en1_init", {26'h0, v[13:8]}, {24'h0, q});
		apb(1, A_PEND, 32'h3FFF, rd);
		apb(1, A_IST, 32'h7, rd);
		pend_m = 32'h0;
		// dense random bursts also hit events landing on a clearing read
		for (int r = 0; r < 6; r++) begin
			apb(1, A_IMASK, {29'h0, r[0], 2'b00}, rd);
			for (int c = 0; c < 30; c++) begin
				v = xs() & xs();
				events <= v[13:0];
				pend_m |= {18'h0, v[13:0]};
				cyc(1);
			end
			events <= 14'h0;
			cyc(80);
			apb(0, A_PEND, 32'h0, rd);
			chk("pend", pend_m, rd);
			apb(0, A_STAT, 32'h0, rd);
			chkb("dev_req", 0, rd[2]);
			chkb("irq", r[0] && pend_m != 0, irq);
			apb(1, A_PEND, pend_m, rd);
			apb(1, A_IST, 32'h7, rd);
			pend_m = 32'h0;
			chkb("irq_clr", 0, irq);
		end
		for (int k = 0; k < 4; k++) begin
			v = xs();
			cmd(1, ta[k], v[7:0], q);
			cmd(0, ta[k], 8'h00, q);
			chk("cmd_rd", {24'h0, v[7:0] & tm[k]}, {24'h0, q});
		end
		chkb("link_oe", v[0], link_led_oe);
		chkb("traffic_oe", v[1], traffic_led_oe);
		chkb("comb_oe", v[2], combined_led_oe);
		cmd(1, DEV_IO_POWER, 8'h07, q);
		link_ok <= 1;
		cyc(3);
		chkb("link_led", 1, link_led);
		chkb("comb", 1, combined_led);
		pkt_activity <= 1;
		cyc(1);
		pkt_activity <= 0;
		cyc(3);
		chkb("traffic", 1, traffic_led);
		chkb("comb", 0, combined_led);
		cyc(ACTL - 4);
		chkb("traffic", 1, traffic_led);
		cyc(2);
		chkb("traffic", 0, traffic_led);
		chkb("comb", 1, combined_led);
		link_ok <= 0;
		cyc(3);
		chkb("link_led", 0, link_led);
		chkb("comb", 0, combined_led);
		cmd(1, DEV_IO_POWER, 8'h00, q);
		link_ok <= 1;
		cyc(3);
		chkb("link_off", 0, link_led);
		chkb("link_oe", 0, link_led_oe);
		give_verdict();
	end
endmodule : irq_init_led_status_bench
`default_nettype wire
